// File: rtl/fbaop_core.sv
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fbaop_defines.svh"
module fbaop_core
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Instruction fetch
  input  wire logic [15:0] i_instr,
  input  wire logic        i_instr_valid,
  output logic             o_instr_ready,
  // File register memory
  output logic      [7:0]  o_fr_addr,
  output logic             o_fr_rd,
  input  wire logic [7:0]  i_fr_rdata,
  output logic             o_fr_we,
  output logic      [7:0]  o_fr_wdata,
  // Status
  output logic             o_skip,
  output logic             o_wdt_timeout
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fbaop_alu_if alu_bus ();

  fbaop_pkg::fbaop_phase_type phase_r;
  fbaop_pkg::fbaop_phase_type phase_nxt;
  fbaop_pkg::fbaop_op_type    op_r;
  fbaop_pkg::fbaop_op_type    op_nxt;

  logic [1:0]  ctrl_r;
  logic [1:0]  ctrl_nxt;
  logic [7:0]  wreg_r;
  logic [7:0]  wreg_nxt;
  logic        carry_r;
  logic        carry_nxt;
  logic        zero_r;
  logic        zero_nxt;
  logic        sleep_r;
  logic        sleep_nxt;
  logic        expiry_r;
  logic        expiry_nxt;
  logic [15:0] instr_r;
  logic [15:0] instr_nxt;
  logic [7:0]  operand_r;
  logic [7:0]  operand_nxt;
  logic [7:0]  result_r;
  logic [7:0]  result_nxt;
  logic        skip_pend_r;
  logic        skip_pend_nxt;
  logic        fr_rd_r;
  logic        fr_rd_nxt;
  logic        fr_we_r;
  logic        fr_we_nxt;
  logic        skip_r;
  logic        skip_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  logic        take;
  logic        dest_file;
  logic        apb_wr;
  logic        apb_setup;
  logic        wdt_clear;
  logic        wdt_tmo;
  logic [7:0]  wdt_count;
  logic [7:0]  wdt_post;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic fbaop_pkg::fbaop_op_type decode_op(input logic [15:0] w);
    fbaop_pkg::fbaop_op_type o;
    o = fbaop_pkg::OP_NOP;
    if (w == `FBAOP_WORD_WDCLR)
      o = fbaop_pkg::OP_WDCLR;
    else if (w[15:9] == `FBAOP_OPC_AND)
      o = fbaop_pkg::OP_AND;
    else if (w[15:9] == `FBAOP_OPC_COMP)
      o = fbaop_pkg::OP_COMP;
    else if (w[15:9] == `FBAOP_OPC_RLN)
      o = fbaop_pkg::OP_RLN;
    else if (w[15:9] == `FBAOP_OPC_RRC)
      o = fbaop_pkg::OP_RRC;
    else if (w[15:11] == `FBAOP_OPC_BCLR)
      o = fbaop_pkg::OP_BCLR;
    else if (w[15:11] == `FBAOP_OPC_BTSS)
      o = fbaop_pkg::OP_BTSS;
    else if (w[15:11] == `FBAOP_OPC_BINV)
      o = fbaop_pkg::OP_BINV;
    return o;
  endfunction

  // Only byte operations carry a destination bit; bit clear and bit invert always write the file, bit test writes nothing
  function automatic logic has_dest(input fbaop_pkg::fbaop_op_type o);
    return (o == fbaop_pkg::OP_AND) || (o == fbaop_pkg::OP_COMP) ||
           (o == fbaop_pkg::OP_RLN) || (o == fbaop_pkg::OP_RRC);
  endfunction

  // ----------------------------------------------------------------
  // Execute unit and watchdog
  // ----------------------------------------------------------------
  assign alu_bus.op       = op_r;
  assign alu_bus.file_val = operand_r;
  assign alu_bus.acc_val  = wreg_r;
  assign alu_bus.bit_sel  = instr_r[10:8];
  assign alu_bus.carry_in = carry_r;

  fbaop_alu u_alu
  (
    .a (alu_bus.alu)
  );

  assign wdt_clear = (phase_r == fbaop_pkg::PH_EXEC) && (op_r == fbaop_pkg::OP_WDCLR); // RULE6

  fbaop_wdt u_wdt
  (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_en      (ctrl_r[`FBAOP_CTRL_WDT_EN]),
    .i_clear   (wdt_clear),
    .o_count   (wdt_count),
    .o_post    (wdt_post),
    .o_timeout (wdt_tmo)
  );

  // ----------------------------------------------------------------
  // Instruction sequencer
  // ----------------------------------------------------------------
  assign take      = (phase_r == fbaop_pkg::PH_DECODE) && ctrl_r[`FBAOP_CTRL_RUN] &&
                     i_instr_valid;
  assign dest_file = !has_dest(op_r) || instr_r[8]; // RULE2
  assign apb_setup = i_psel && !i_penable;
  assign apb_wr    = i_psel && i_penable && i_pwrite;

  always_comb
  begin
    phase_nxt     = phase_r;
    op_nxt        = op_r;
    instr_nxt     = instr_r;
    operand_nxt   = operand_r;
    result_nxt    = result_r;
    skip_pend_nxt = skip_pend_r;
    fr_rd_nxt     = 1'b0;
    fr_we_nxt     = 1'b0;
    skip_nxt      = 1'b0;
    case (phase_r)
      fbaop_pkg::PH_DECODE:
        if (take)
        begin
          instr_nxt     = i_instr;
          // A word fetched behind a taken skip runs as a NOP
          op_nxt        = skip_pend_r ? fbaop_pkg::OP_NOP : decode_op(i_instr); // RULE4
          skip_pend_nxt = 1'b0;
          fr_rd_nxt     = !skip_pend_r;
          phase_nxt     = fbaop_pkg::PH_READ; // RULE10
        end
      fbaop_pkg::PH_READ:
      begin
        operand_nxt = i_fr_rdata; // RULE10
        phase_nxt   = fbaop_pkg::PH_EXEC;
      end
      fbaop_pkg::PH_EXEC:
      begin
        result_nxt = alu_bus.result;
        if (alu_bus.skip)
        begin
          skip_pend_nxt = 1'b1; // RULE4
          skip_nxt      = 1'b1;
        end
        // NOP, skip test and watchdog clear write nothing
        fr_we_nxt = dest_file && (op_r != fbaop_pkg::OP_NOP) &&
                    (op_r != fbaop_pkg::OP_BTSS) && (op_r != fbaop_pkg::OP_WDCLR); // RULE10
        phase_nxt = fbaop_pkg::PH_WRITE;
      end
      fbaop_pkg::PH_WRITE:
        phase_nxt = fbaop_pkg::PH_DECODE;
      default:
        phase_nxt = fbaop_pkg::PH_DECODE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      phase_r     <= fbaop_pkg::PH_DECODE;
      op_r        <= fbaop_pkg::OP_NOP;
      instr_r     <= 16'h0000;
      operand_r   <= 8'h00;
      result_r    <= 8'h00;
      skip_pend_r <= 1'b0;
      fr_rd_r     <= 1'b0;
      fr_we_r     <= 1'b0;
      skip_r      <= 1'b0;
    end
    else if (i_ce)
    begin
      phase_r     <= phase_nxt;
      op_r        <= op_nxt;
      instr_r     <= instr_nxt;
      operand_r   <= operand_nxt;
      result_r    <= result_nxt;
      skip_pend_r <= skip_pend_nxt;
      fr_rd_r     <= fr_rd_nxt;
      fr_we_r     <= fr_we_nxt;
      skip_r      <= skip_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, flags and control
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    wreg_nxt   = wreg_r;
    carry_nxt  = carry_r;
    zero_nxt   = zero_r;
    sleep_nxt  = sleep_r;
    expiry_nxt = expiry_r;
    if (apb_wr && (i_paddr == `FBAOP_ADDR_CTRL))
      ctrl_nxt = i_pwdata[1:0];
    if (apb_wr && (i_paddr == `FBAOP_ADDR_WREG))
      wreg_nxt = i_pwdata[7:0];
    if (apb_wr && (i_paddr == `FBAOP_ADDR_STATUS))
    begin
      carry_nxt = i_pwdata[`FBAOP_ST_CARRY];
      zero_nxt  = i_pwdata[`FBAOP_ST_ZERO];
    end
    // Core updates land after the bus write so hardware wins a collision
    if (phase_r == fbaop_pkg::PH_EXEC)
    begin
      if (alu_bus.upd_zero)
        zero_nxt = alu_bus.zero; // RULE1 RULE7
      if (alu_bus.upd_carry)
        carry_nxt = alu_bus.carry_out; // RULE9
    end
    if ((phase_r == fbaop_pkg::PH_WRITE) && !dest_file)
      wreg_nxt = result_r; // RULE2
    if (wdt_tmo)
      expiry_nxt = 1'b0;
    if (wdt_clear)
    begin
      expiry_nxt = 1'b1; // RULE6
      sleep_nxt  = 1'b1; // RULE6
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_r   <= `FBAOP_CTRL_RST;
      wreg_r   <= `FBAOP_WREG_RST;
      carry_r  <= 1'b0;
      zero_r   <= 1'b0;
      sleep_r  <= 1'b1;
      expiry_r <= 1'b1;
    end
    else if (i_ce)
    begin
      ctrl_r   <= ctrl_nxt;
      wreg_r   <= wreg_nxt;
      carry_r  <= carry_nxt;
      zero_r   <= zero_nxt;
      sleep_r  <= sleep_nxt;
      expiry_r <= expiry_nxt;
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle so the access phase needs no wait
  always_comb
  begin
    prdata_nxt = prdata_r;
    if (apb_setup)
    begin
      case (i_paddr)
        `FBAOP_ADDR_CTRL:
          prdata_nxt = {30'h0, ctrl_r};
        `FBAOP_ADDR_WREG:
          prdata_nxt = {24'h0, wreg_r};
        `FBAOP_ADDR_STATUS:
          prdata_nxt = {28'h0, expiry_r, sleep_r, zero_r, carry_r};
        `FBAOP_ADDR_WDT:
          prdata_nxt = {16'h0, wdt_post, wdt_count};
        default:
          prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      prdata_r <= 32'h0;
    else if (i_ce)
      prdata_r <= prdata_nxt;
  end

  assign o_prdata  = prdata_r;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable &&
                     (i_paddr != `FBAOP_ADDR_CTRL) && (i_paddr != `FBAOP_ADDR_WREG) &&
                     (i_paddr != `FBAOP_ADDR_STATUS) && (i_paddr != `FBAOP_ADDR_WDT);

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_instr_ready = (phase_r == fbaop_pkg::PH_DECODE) && ctrl_r[`FBAOP_CTRL_RUN] && i_ce;
  assign o_fr_addr     = instr_r[7:0];
  assign o_fr_rd       = fr_rd_r;
  assign o_fr_we       = fr_we_r; // RULE3 RULE5
  assign o_fr_wdata    = result_r;
  assign o_skip        = skip_r;
  assign o_wdt_timeout = wdt_tmo;

endmodule
`default_nettype wire

// File: rtl/fbaop_defines.svh
`ifndef FBAOP_DEFINES_SVH
`define FBAOP_DEFINES_SVH
// How it works
// RULE1: AND merges accumulator with file register 0..255, only null-result flag updates.
// RULE2: Destination bit 0 sends result to accumulator, 1 back to file register.
// RULE3: Bit clear zeroes chosen bit 0..7 of file register, flags unchanged.
// RULE4: Bit test skip: set bit discards prefetched word as NOP, two cycles, no flags.
// RULE5: Bit invert flips chosen bit and writes it back, flags untouched.
// RULE6: Watchdog clear zeroes counter and postscaler, sets expiry and sleep-entry bits.
// RULE7: Complement inverts file register to selected destination, updates null-result flag.
// RULE8: Rotate left without carry moves bit 7 into bit 0, no flags.
// RULE9: Rotate right through carry: old bit 0 to carry, old carry to bit 7.
// RULE10: Each instruction runs decode, read, execute, write; watchdog clear skips write.

// ----------------------------------------------------------------
// Register map (byte addresses on APB)
// ----------------------------------------------------------------
`define FBAOP_ADDR_CTRL     12'h000
`define FBAOP_ADDR_WREG     12'h004
`define FBAOP_ADDR_STATUS   12'h008
`define FBAOP_ADDR_WDT      12'h00C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FBAOP_CTRL_RUN      0
`define FBAOP_CTRL_WDT_EN   1
`define FBAOP_ST_CARRY      0
`define FBAOP_ST_ZERO       1
`define FBAOP_ST_SLEEP      2
`define FBAOP_ST_EXPIRY     3
`define FBAOP_CTRL_RST      2'h0
`define FBAOP_WREG_RST      8'h00
`define FBAOP_WDT_ZERO      8'h00

// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define FBAOP_OPC_AND       7'h05
`define FBAOP_OPC_COMP      7'h09
`define FBAOP_OPC_RRC       7'h0C
`define FBAOP_OPC_RLN       7'h11
`define FBAOP_OPC_BCLR      5'h11
`define FBAOP_OPC_BTSS      5'h12
`define FBAOP_OPC_BINV      5'h07
`define FBAOP_WORD_WDCLR    16'h0004

// ----------------------------------------------------------------
// Watchdog timing
// ----------------------------------------------------------------
`define FBAOP_WDT_POST_MAX  8'h7F
`endif

// File: rtl/fbaop_pkg.sv
package fbaop_pkg;

  typedef enum logic [3:0]
  {
    OP_NOP,
    OP_AND,
    OP_COMP,
    OP_RLN,
    OP_RRC,
    OP_BCLR,
    OP_BTSS,
    OP_BINV,
    OP_WDCLR
  } fbaop_op_type;

  typedef enum logic [1:0]
  {
    PH_DECODE,
    PH_READ,
    PH_EXEC,
    PH_WRITE
  } fbaop_phase_type;

endpackage

// File: rtl/fbaop_alu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fbaop_alu_if;
  fbaop_pkg::fbaop_op_type op;
  logic [7:0]              file_val;
  logic [7:0]              acc_val;
  logic [2:0]              bit_sel;
  logic                    carry_in;
  logic [7:0]              result;
  logic                    zero;
  logic                    carry_out;
  logic                    upd_zero;
  logic                    upd_carry;
  logic                    skip;

  modport core (output op, file_val, acc_val, bit_sel, carry_in,
                input result, zero, carry_out, upd_zero, upd_carry, skip);
  modport alu  (input op, file_val, acc_val, bit_sel, carry_in,
                output result, zero, carry_out, upd_zero, upd_carry, skip);
endinterface
`default_nettype wire

// File: rtl/fbaop_alu.sv
`timescale 1ns/1ps
`default_nettype none
module fbaop_alu
(
  fbaop_alu_if.alu a
);

  logic [7:0] mask;

  always_comb
  begin
    mask        = 8'h01 << a.bit_sel;
    a.result    = a.file_val;
    a.carry_out = a.carry_in;
    a.upd_zero  = 1'b0;
    a.upd_carry = 1'b0;
    a.skip      = 1'b0;
    case (a.op)
      fbaop_pkg::OP_AND:
      begin
        a.result   = a.acc_val & a.file_val; // RULE1
        a.upd_zero = 1'b1; // RULE1
      end
      fbaop_pkg::OP_COMP:
      begin
        a.result   = ~a.file_val; // RULE7
        a.upd_zero = 1'b1; // RULE7
      end
      fbaop_pkg::OP_RLN:
        a.result = {a.file_val[6:0], a.file_val[7]}; // RULE8
      fbaop_pkg::OP_RRC:
      begin
        a.result    = {a.carry_in, a.file_val[7:1]}; // RULE9
        a.carry_out = a.file_val[0]; // RULE9
        a.upd_carry = 1'b1; // RULE9
      end
      fbaop_pkg::OP_BCLR:
        a.result = a.file_val & ~mask; // RULE3
      fbaop_pkg::OP_BINV:
        a.result = a.file_val ^ mask; // RULE5
      fbaop_pkg::OP_BTSS:
        a.skip = |(a.file_val & mask); // RULE4
      default:
        a.result = a.file_val;
    endcase
    a.zero = (a.result == 8'h00);
  end

endmodule
`default_nettype wire

// File: rtl/fbaop_wdt.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbaop_defines.svh"
module fbaop_wdt
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  input  wire logic       i_en,
  input  wire logic       i_clear,
  output logic      [7:0] o_count,
  output logic      [7:0] o_post,
  output logic            o_timeout
);

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] post_r;
  logic [7:0] post_nxt;
  logic       tmo_nxt;
  logic       tmo_r;

  // ----------------------------------------------------------------
  // Counter and postscaler
  // ----------------------------------------------------------------
  always_comb
  begin
    count_nxt = count_r;
    post_nxt  = post_r;
    tmo_nxt   = 1'b0;
    if (i_clear)
    begin
      count_nxt = `FBAOP_WDT_ZERO; // RULE6
      post_nxt  = `FBAOP_WDT_ZERO; // RULE6
    end
    else if (i_en)
    begin
      count_nxt = count_r + 8'h01;
      if (count_r == 8'hFF)
      begin
        if (post_r == `FBAOP_WDT_POST_MAX)
        begin
          post_nxt = `FBAOP_WDT_ZERO;
          tmo_nxt  = 1'b1;
        end
        else
          post_nxt = post_r + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      count_r <= `FBAOP_WDT_ZERO;
      post_r  <= `FBAOP_WDT_ZERO;
      tmo_r   <= 1'b0;
    end
    else if (i_ce)
    begin
      count_r <= count_nxt;
      post_r  <= post_nxt;
      tmo_r   <= tmo_nxt;
    end
  end

  assign o_count   = count_r;
  assign o_post    = post_r;
  assign o_timeout = tmo_r;

endmodule
`default_nettype wire

// File: testbench/fbaop_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// File register memory seen by the core
// ----------------------------------------------------------------
module fbaop_mem_model
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_fr_addr,
  input  wire logic       i_fr_rd,
  input  wire logic       i_fr_we,
  input  wire logic [7:0] i_fr_wdata,
  output logic      [7:0] o_fr_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_r = 8'h00;

  // Plain always so the bench may preload words between instructions
  always @(posedge i_clk)
  begin
    if (i_fr_we)
      mem[i_fr_addr] <= i_fr_wdata;
    if (i_fr_rd)
      last_r <= mem[i_fr_addr];
  end

  // Read is combinational; off the read strobe the bus shows junk, not stale data
  assign o_fr_rdata = i_fr_rd ? mem[i_fr_addr] : ~last_r;
endmodule
`default_nettype wire

// File: testbench/fbaop_core_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbaop_defines.svh"
module fbaop_core_props
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [15:0] i_instr,
  input  wire logic        i_instr_valid,
  input  wire logic        o_instr_ready,
  input  wire logic [7:0]  o_fr_addr,
  input  wire logic        o_fr_rd,
  input  wire logic [7:0]  i_fr_rdata,
  input  wire logic        o_fr_we,
  input  wire logic [7:0]  o_fr_wdata,
  input  wire logic        o_skip
);
  logic [15:0] held_r;
  logic [7:0]  rd_r;
  logic        pend_r;
  logic        take;

  assign take = i_instr_valid && o_instr_ready;

  // Remember the taken word, the operand read, and a pending skip
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      held_r <= 16'h0000;
      rd_r   <= 8'h00;
      pend_r <= 1'b0;
    end
    else
    begin
      if (take)
        held_r <= i_instr;
      if (o_fr_rd)
        rd_r <= i_fr_rdata;
      if (o_skip)
        pend_r <= 1'b1;
      else if (take)
        pend_r <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_take_read;
    take && !pend_r |=> o_fr_rd && !o_instr_ready && o_fr_addr == held_r[7:0];
  endproperty
  a_take_read: assert property (p_take_read)
    else $error("file read does not follow an accepted word");

  property p_phase_order;
    o_fr_rd |=> (!o_fr_rd && !o_fr_we) ##1 (!o_fr_rd && !o_instr_ready);
  endproperty
  a_phase_order: assert property (p_phase_order)
    else $error("execute and write phases out of order");

  property p_write_src;
    o_fr_we |-> $past(o_fr_rd, 2);
  endproperty
  a_write_src: assert property (p_write_src)
    else $error("file write without read two cycles before");

  property p_wdclr_nowrite;
    take && !pend_r && i_instr == `FBAOP_WORD_WDCLR |=> ##2 !o_fr_we;
  endproperty
  a_wdclr_nowrite: assert property (p_wdclr_nowrite)
    else $error("watchdog clear wrote a file register");

  property p_and_dest;
    $past(o_fr_rd, 2) && held_r[15:9] == `FBAOP_OPC_AND |-> o_fr_we == held_r[8];
  endproperty
  a_and_dest: assert property (p_and_dest)
    else $error("and result sent to wrong destination");

  property p_bclr_data;
    o_fr_we && held_r[15:11] == `FBAOP_OPC_BCLR
      |-> o_fr_wdata == (rd_r & ~(8'h01 << held_r[10:8]));
  endproperty
  a_bclr_data: assert property (p_bclr_data)
    else $error("bit clear wrote wrong value");

  property p_binv_data;
    o_fr_we && held_r[15:11] == `FBAOP_OPC_BINV
      |-> o_fr_wdata == (rd_r ^ (8'h01 << held_r[10:8]));
  endproperty
  a_binv_data: assert property (p_binv_data)
    else $error("bit invert wrote wrong value");

  property p_skip_flag;
    $past(o_fr_rd, 2) && held_r[15:11] == `FBAOP_OPC_BTSS
      |-> o_skip == rd_r[held_r[10:8]] && !o_fr_we;
  endproperty
  a_skip_flag: assert property (p_skip_flag)
    else $error("skip pulse does not match tested bit");

  property p_skip_nop;
    take && pend_r |=> !o_fr_rd ##2 !o_fr_we;
  endproperty
  a_skip_nop: assert property (p_skip_nop)
    else $error("discarded word was executed");
endmodule

bind fbaop_core fbaop_core_props u_fbaop_core_props
(
  .i_clk         (i_clk),
  .i_rstn        (i_rstn),
  .i_instr       (i_instr),
  .i_instr_valid (i_instr_valid),
  .o_instr_ready (o_instr_ready),
  .o_fr_addr     (o_fr_addr),
  .o_fr_rd       (o_fr_rd),
  .i_fr_rdata    (i_fr_rdata),
  .o_fr_we       (o_fr_we),
  .o_fr_wdata    (o_fr_wdata),
  .o_skip        (o_skip)
);
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbaop_defines.svh"
module testbench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [15:0] instr = 16'h0000;
  logic        instr_valid = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        instr_ready;
  logic [7:0]  fr_addr;
  logic        fr_rd;
  logic [7:0]  fr_rdata;
  logic        fr_we;
  logic [7:0]  fr_wdata;
  logic        skip;
  logic        wdt_timeout;
  logic [31:0] q;
  logic        e;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          skips = 0;

  always #5 clk = ~clk;

  fbaop_core u_fbaop_core (.i_clk(clk), .i_rstn(rstn), .i_ce(1'b1), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_instr(instr),
    .i_instr_valid(instr_valid), .o_instr_ready(instr_ready), .o_fr_addr(fr_addr),
    .o_fr_rd(fr_rd), .i_fr_rdata(fr_rdata), .o_fr_we(fr_we), .o_fr_wdata(fr_wdata),
    .o_skip(skip), .o_wdt_timeout(wdt_timeout));

  fbaop_mem_model u_fbaop_mem_model (.i_clk(clk), .i_fr_addr(fr_addr), .i_fr_rd(fr_rd),
    .i_fr_we(fr_we), .i_fr_wdata(fr_wdata), .o_fr_rdata(fr_rdata));

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task conclude;
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Each call starts on a fresh edge so no strobe is driven twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask

  task exec(input logic [15:0] w);
    @(posedge clk);
    instr <= w;
    instr_valid <= 1'b1;
    @(negedge clk);
    while (instr_ready !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    instr_valid <= 1'b0;
    instr <= ~w;
    @(negedge clk);
    while (instr_ready !== 1'b1)
      @(negedge clk);
  endtask

  function automatic logic [15:0] fb(input logic [6:0] o, input logic d, input logic [7:0] f);
    return {o, d, f};
  endfunction

  function automatic logic [15:0] bb(input logic [4:0] o, input logic [2:0] b,
    input logic [7:0] f);
    return {o, b, f};
  endfunction

  task poke(input logic [7:0] a, input logic [7:0] v);
    u_fbaop_mem_model.mem[a] = v;
  endtask

  task chk_mem(input logic [7:0] a, input logic [7:0] exp);
    chk({24'h000000, u_fbaop_mem_model.mem[a]}, {24'h000000, exp});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd_chk(`FBAOP_ADDR_STATUS, 32'h0000000C);
    rd_chk(`FBAOP_ADDR_WREG, 32'h00000000);
    apb(1'b1, 12'h010, 32'h00000003);
    chk({31'h0, e}, 32'h00000001);
    apb(1'b0, 12'h010, 32'h00000000);
    chk(q, 32'h00000000);
    apb(1'b1, `FBAOP_ADDR_WDT, 32'h0000FFFF);
    rd_chk(`FBAOP_ADDR_WDT, 32'h00000000);
    rd_chk(`FBAOP_ADDR_CTRL, 32'h00000000);
    apb(1'b1, `FBAOP_ADDR_CTRL, 32'h00000001);
  endtask

  task t_and;
    apb(1'b1, `FBAOP_ADDR_WREG, 32'h00000017);
    apb(1'b1, `FBAOP_ADDR_STATUS, 32'h00000001);
    poke(8'h05, 8'hC2);
    exec(fb(`FBAOP_OPC_AND, 1'b1, 8'h05));
    chk_mem(8'h05, 8'h02);
    rd_chk(`FBAOP_ADDR_WREG, 32'h00000017);
    rd_chk(`FBAOP_ADDR_STATUS, 32'h0000000D);
    poke(8'hFF, 8'h28);
    exec(fb(`FBAOP_OPC_AND, 1'b0, 8'hFF));
    rd_chk(`FBAOP_ADDR_WREG, 32'h00000000);
    chk_mem(8'hFF, 8'h28);
    rd_chk(`FBAOP_ADDR_STATUS, 32'h0000000F);
  endtask

  task t_comp;
    poke(8'h10, 8'h13);
    exec(fb(`FBAOP_OPC_COMP, 1'b0, 8'h10));
    rd_chk(`FBAOP_ADDR_WREG, 32'h000000EC);
    chk_mem(8'h10, 8'h13);
    rd_chk(`FBAOP_ADDR_STATUS, 32'h0000000D);
    poke(8'h11, 8'hFF);
    exec(fb(`FBAOP_OPC_COMP, 1'b1, 8'h11));
    chk_mem(8'h11, 8'h00);
    rd_chk(`FBAOP_ADDR_STATUS, 32'h0000000F);
  endtask

  task t_rotate;
    poke(8'h20, 8'hEB);
    exec(fb(`FBAOP_OPC_RLN, 1'b1, 8'h20));
    chk_mem(8'h20, 8'hD7);
    exec(fb(`FBAOP_OPC_RLN, 1'b0, 8'h20));
    rd_chk(`FBAOP_ADDR_WREG, 32'h000000AF);
    rd_chk(`FBAOP_ADDR_STATUS, 32'h0000000F);
    apb(1'b1, `FBAOP_ADDR_STATUS, 32'h00000000);
    poke(8'h30, 8'hE6);
    exec(fb(`FBAOP_OPC_RRC, 1'b0, 8'h30));
    rd_chk(`FBAOP_ADDR_WREG, 32'h00000073);
    poke(8'h31, 8'h01);
    exec(fb(`FBAOP_OPC_RRC, 1'b1, 8'h31));
    chk_mem(8'h31, 8'h00);
    rd_chk(`FBAOP_ADDR_STATUS, 32'h0000000D);
    exec(fb(`FBAOP_OPC_RRC, 1'b1, 8'h31));
    chk_mem(8'h31, 8'h80);
    rd_chk(`FBAOP_ADDR_STATUS, 32'h0000000C);
  endtask

  task t_bits;
    apb(1'b1, `FBAOP_ADDR_STATUS, 32'h00000003);
    for (int b = 0; b < 8; b++)
    begin
      poke(8'h40, 8'hFF);
      exec(bb(`FBAOP_OPC_BCLR, b[2:0], 8'h40));
      chk_mem(8'h40, ~(8'h01 << b));
      poke(8'h41, 8'h75);
      exec(bb(`FBAOP_OPC_BINV, b[2:0], 8'h41));
      chk_mem(8'h41, 8'h75 ^ (8'h01 << b));
    end
    rd_chk(`FBAOP_ADDR_STATUS, 32'h0000000F);
  endtask

  task t_skip;
    apb(1'b1, `FBAOP_ADDR_WREG, 32'h00000000);
    poke(8'h50, 8'h02);
    exec(bb(`FBAOP_OPC_BTSS, 3'h1, 8'h50));
    exec(fb(`FBAOP_OPC_COMP, 1'b0, 8'h50));
    rd_chk(`FBAOP_ADDR_WREG, 32'h00000000);
    chk(skips, 32'h00000001);
    rd_chk(`FBAOP_ADDR_STATUS, 32'h0000000F);
    exec(bb(`FBAOP_OPC_BTSS, 3'h0, 8'h50));
    exec(fb(`FBAOP_OPC_COMP, 1'b0, 8'h50));
    rd_chk(`FBAOP_ADDR_WREG, 32'h000000FD);
    chk(skips, 32'h00000001);
  endtask

  // Full wrap takes tens of thousands of cycles; freezing the count before
  // the clear lets the zero be read back exactly
  task t_wdt;
    apb(1'b1, `FBAOP_ADDR_CTRL, 32'h00000003);
    @(negedge clk);
    while (wdt_timeout !== 1'b1)
      @(negedge clk);
    rd_chk(`FBAOP_ADDR_STATUS, 32'h00000005);
    repeat (300) @(posedge clk);
    apb(1'b1, `FBAOP_ADDR_CTRL, 32'h00000001);
    exec(`FBAOP_WORD_WDCLR);
    rd_chk(`FBAOP_ADDR_WDT, 32'h00000000);
    rd_chk(`FBAOP_ADDR_STATUS, 32'h0000000D);
  endtask

  // ----------------------------------------------------------------
  // Sequence, monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (skip === 1'b1)
      skips++;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fails++;
      conclude;
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_and;
    t_comp;
    t_rotate;
    t_bits;
    t_skip;
    t_wdt;
    conclude;
  end
endmodule
`default_nettype wire
